// >>> verilog/bpsc_ctrl.v
// Self-programming control register, sequencer and section decode.
//
// Function
// - 4K flash: fuse 11/10/01/00 puts boot start at F80/F00/E00/C00.
// - 4K flash: 000-BFF reads concurrently, C00-FFF stalls during programming.
// - 4K flash: 32-word pages, page from pointer 12:6, word 5:1.
// - 8K flash: boot start 1F80/1F00/1E00/1C00; stall section 1C00-1FFF.
// - 8K flash: 64-word pages, page from pointer 13:7, word 6:1.
// - Pointer bits above the page field are ignored.
// - Pointer bit 0 zero for commands; selects byte on program reads.
// - Word index picks buffer word; must be zero on page write.
// - Page field selects the page erased or written.
// - Control register at 0x37, resets zero, bit 5 reads zero.
// - Ready interrupt needs enable bit and global interrupt flag.
// - Ready interrupt is a level while enable bit clear.
// - Enable bit stays high until erase or write completes.
// - Busy flag set on concurrent-section program; blocks its reads.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`include "bpsc_consts.vh"
module bpsc_ctrl #(
   parameter PROG_CYCLES = `BPSC_PROG_CYCLES
) (
   // Clock and reset
   input  wire        ref_clk_in,
   input  wire        reset_n_in,
   input  wire        clk_en_in,
   // Static configuration
   input  wire        size_8k_in,
   input  wire [1:0]  boot_size_fuse_in,
   // Register port
   input  wire [7:0]  reg_addr_in,
   input  wire [7:0]  reg_wdata_in,
   input  wire        reg_wr_in,
   input  wire        reg_rd_in,
   output reg  [7:0]  reg_rdata_out,
   // Core side
   input  wire        global_int_en_in,
   input  wire        spm_exec_in,
   input  wire [15:0] pointer_in,
   input  wire [15:0] spm_data_in,
   input  wire        lpm_exec_in,
   // Flash side
   output reg         flash_erase_out,
   output reg         flash_write_out,
   output reg  [6:0]  flash_page_out,
   output reg         buf_fill_out,
   output reg  [5:0]  buf_word_out,
   output reg  [15:0] buf_data_out,
   output reg         buf_clear_out,
   output wire        lpm_byte_sel_out,
   output wire        concurrent_read_blocked_out,
   output wire        lpm_addr_blocked_out,
   output wire        cpu_halt_out,
   output wire [12:0] boot_start_out,
   // Interrupts
   output wire        prog_ready_irq_out,
   output wire        irq_out
);
   // ------------------------------------------------------------
   // Configuration sampling
   // ------------------------------------------------------------
   // Held in flops so a glitching strap cannot move boundaries mid-run.
   reg        size_8k_q;
   reg [1:0]  fuse_q;
   reg        cfg_taken_q;
   always @(posedge ref_clk_in) begin
      if (!reset_n_in) begin
         cfg_taken_q <= 1'b0;
         size_8k_q   <= 1'b0;
         fuse_q      <= 2'h0;
      end else if (clk_en_in && !cfg_taken_q) begin
         cfg_taken_q <= 1'b1;
         size_8k_q   <= size_8k_in;
         fuse_q      <= boot_size_fuse_in;
      end
   end

   wire [6:0] page_field;
   wire [5:0] word_field;
   wire       ptr_conc;
   bpsc_addr_map u_map (
      .size_8k_in             (size_8k_q),
      .boot_size_fuse_in      (fuse_q),
      .pointer_in             (pointer_in),
      .boot_start_out         (boot_start_out),
      .ptr_in_concurrent_out  (ptr_conc),
      .page_number_field_out  (page_field),
      .in_page_word_index_out (word_field),
      .byte_sel_out           (lpm_byte_sel_out)
   );

   // ------------------------------------------------------------
   // Control register and sequencer
   // ------------------------------------------------------------
   localparam ST_IDLE = 2'h0;
   localparam ST_ARM  = 2'h1;
   localparam ST_PROG = 2'h2;

   reg [1:0]  state_q;
   reg [2:0]  arm_cnt_q;
   reg [31:0] prog_cnt_q;
   reg        int_en_q;
   reg        busy_q;
   reg [4:0]  cmd_q;
   reg        halt_q;
   reg [1:0]  stat_q;
   reg [1:0]  mask_q;

   wire csr_wr  = reg_wr_in && (reg_addr_in == `BPSC_CSR_OFS);
   wire stat_wr = reg_wr_in && (reg_addr_in == `BPSC_STAT_OFS);
   wire mask_wr = reg_wr_in && (reg_addr_in == `BPSC_MASK_OFS);
   wire [4:0] wcmd = reg_wdata_in[4:0];
   wire cmd_legal = (wcmd == `BPSC_CMD_WRITE) || (wcmd == `BPSC_CMD_ERASE) ||
                    (wcmd == `BPSC_CMD_REEN)  || (wcmd == `BPSC_CMD_LOCK) ||
                    (wcmd == `BPSC_CMD_FILL);
   wire self_program_enable = cmd_q[`BPSC_BIT_SPEN];
   wire done_pulse = (state_q == ST_PROG) && (prog_cnt_q == 32'h0);
   wire spm_go = (state_q == ST_ARM) && spm_exec_in;

   always @(posedge ref_clk_in) begin
      if (!reset_n_in) begin
         state_q         <= ST_IDLE;
         arm_cnt_q       <= 3'h0;
         prog_cnt_q      <= 32'h0;
         int_en_q        <= 1'b0;
         busy_q          <= 1'b0;
         cmd_q           <= 5'h00;
         halt_q          <= 1'b0;
         stat_q          <= 2'h0;
         mask_q          <= 2'h0;
         flash_erase_out <= 1'b0;
         flash_write_out <= 1'b0;
         flash_page_out  <= 7'h00;
         buf_fill_out    <= 1'b0;
         buf_word_out    <= 6'h00;
         buf_data_out    <= 16'h0000;
         buf_clear_out   <= 1'b0;
      end else if (clk_en_in) begin
         flash_erase_out <= 1'b0;
         flash_write_out <= 1'b0;
         buf_fill_out    <= 1'b0;
         buf_clear_out   <= 1'b0;
         if (csr_wr)
            int_en_q <= reg_wdata_in[`BPSC_BIT_INT_EN];
         if (mask_wr)
            mask_q <= reg_wdata_in[1:0];
         // Set wins over write-one-to-clear.
         stat_q[0] <= (stat_q[0] & ~(stat_wr & reg_wdata_in[0])) |
                      done_pulse;
         stat_q[1] <= (stat_q[1] & ~(stat_wr & reg_wdata_in[1])) |
                      (csr_wr && state_q != ST_PROG && !cmd_legal);
         case (state_q)
            ST_IDLE: begin
               if (csr_wr && cmd_legal) begin
                  cmd_q     <= wcmd;
                  arm_cnt_q <= `BPSC_ARM_CYCLES;
                  state_q   <= ST_ARM;
               end
            end
            ST_ARM: begin
               if (spm_go) begin
                  case (cmd_q)
                     `BPSC_CMD_ERASE, `BPSC_CMD_WRITE: begin
                        flash_page_out  <= page_field;
                        flash_erase_out <= cmd_q == `BPSC_CMD_ERASE;
                        flash_write_out <= cmd_q == `BPSC_CMD_WRITE;
                        busy_q     <= busy_q | ptr_conc;
                        halt_q     <= ~ptr_conc;
                        prog_cnt_q <= PROG_CYCLES - 1;
                        state_q    <= ST_PROG;
                     end
                     `BPSC_CMD_FILL: begin
                        buf_fill_out <= 1'b1;
                        buf_word_out <= word_field;
                        buf_data_out <= spm_data_in;
                        busy_q  <= 1'b0;
                        cmd_q   <= 5'h00;
                        state_q <= ST_IDLE;
                     end
                     `BPSC_CMD_REEN: begin
                        busy_q        <= 1'b0;
                        buf_clear_out <= 1'b1;
                        cmd_q         <= 5'h00;
                        state_q       <= ST_IDLE;
                     end
                     default: begin
                        cmd_q   <= 5'h00;
                        state_q <= ST_IDLE;
                     end
                  endcase
               end else if (arm_cnt_q == 3'h1) begin
                  cmd_q   <= 5'h00;
                  state_q <= ST_IDLE;
               end else begin
                  arm_cnt_q <= arm_cnt_q - 3'h1;
               end
            end
            ST_PROG: begin
               if (done_pulse) begin
                  cmd_q   <= 5'h00;
                  halt_q  <= 1'b0;
                  state_q <= ST_IDLE;
               end else begin
                  prog_cnt_q <= prog_cnt_q - 32'h1;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Read port
   // ------------------------------------------------------------
   always @(posedge ref_clk_in) begin
      if (!reset_n_in)
         reg_rdata_out <= `BPSC_CSR_RESET;
      else if (clk_en_in) begin
         if (reg_rd_in) begin
            case (reg_addr_in)
               `BPSC_CSR_OFS:
                  reg_rdata_out <= {int_en_q, busy_q, 1'b0, cmd_q};
               `BPSC_STAT_OFS: reg_rdata_out <= {6'h00, stat_q};
               `BPSC_MASK_OFS: reg_rdata_out <= {6'h00, mask_q};
               default:        reg_rdata_out <= 8'h00;
            endcase
         end else
            reg_rdata_out <= 8'h00;
      end
   end

   assign concurrent_read_blocked_out = busy_q;
   assign lpm_addr_blocked_out = busy_q && ptr_conc && lpm_exec_in;
   assign cpu_halt_out = halt_q;
   // Level while enabled and no operation pending.
   assign prog_ready_irq_out = int_en_q && global_int_en_in &&
                               !self_program_enable;
   assign irq_out = |(stat_q & mask_q);
endmodule // bpsc_ctrl

// >>> verilog/bpsc_consts.vh
// Constants for the boot partition and self-programming controller.
`ifndef BPSC_CONSTS_VH
`define BPSC_CONSTS_VH
`define BPSC_CSR_OFS        8'h37
`define BPSC_STAT_OFS       8'h38
`define BPSC_MASK_OFS       8'h39
`define BPSC_CSR_RESET      8'h00
`define BPSC_BIT_INT_EN     7
`define BPSC_BIT_BUSY       6
`define BPSC_BIT_REENABLE   4
`define BPSC_BIT_LOCKSET    3
`define BPSC_BIT_PAGE_WRITE_CMD      2
`define BPSC_BIT_PAGE_ERASE_CMD      1
`define BPSC_BIT_SPEN       0
`define BPSC_CMD_WRITE      5'h05
`define BPSC_CMD_ERASE      5'h03
`define BPSC_CMD_REEN       5'h11
`define BPSC_CMD_LOCK       5'h09
`define BPSC_CMD_FILL       5'h01
`define BPSC_ARM_CYCLES     3'h4
`define BPSC_PROG_TIME_US   3700
`define BPSC_CLK_MHZ        50
`define BPSC_PROG_CYCLES    (`BPSC_PROG_TIME_US * `BPSC_CLK_MHZ)
`define BPSC_STALL_4K       13'h0C00
`define BPSC_STALL_8K       13'h1C00
`define BPSC_BOOT_4K_11     13'h0F80
`define BPSC_BOOT_4K_10     13'h0F00
`define BPSC_BOOT_4K_01     13'h0E00
`define BPSC_BOOT_4K_00     13'h0C00
`define BPSC_BOOT_8K_11     13'h1F80
`define BPSC_BOOT_8K_10     13'h1F00
`define BPSC_BOOT_8K_01     13'h1E00
`define BPSC_BOOT_8K_00     13'h1C00
`endif

// >>> verilog/bpsc_addr_map.v
// Pointer decode and section boundaries for both flash sizes.
`timescale 1ns/1ps
`include "bpsc_consts.vh"
module bpsc_addr_map (
   // Configuration
   input  wire        size_8k_in,
   input  wire [1:0]  boot_size_fuse_in,
   // Pointer
   input  wire [15:0] pointer_in,
   // Decoded
   output reg  [12:0] boot_start_out,
   output wire        ptr_in_concurrent_out,
   output wire [6:0]  page_number_field_out,
   output wire [5:0]  in_page_word_index_out,
   output wire        byte_sel_out
);
   wire [12:0] word_addr = size_8k_in ? pointer_in[13:1]
                                      : {1'b0, pointer_in[12:1]};
   always @* begin
      case ({size_8k_in, boot_size_fuse_in})
         3'h3: boot_start_out = `BPSC_BOOT_4K_11;
         3'h2: boot_start_out = `BPSC_BOOT_4K_10;
         3'h1: boot_start_out = `BPSC_BOOT_4K_01;
         3'h0: boot_start_out = `BPSC_BOOT_4K_00;
         3'h7: boot_start_out = `BPSC_BOOT_8K_11;
         3'h6: boot_start_out = `BPSC_BOOT_8K_10;
         3'h5: boot_start_out = `BPSC_BOOT_8K_01;
         default: boot_start_out = `BPSC_BOOT_8K_00;
      endcase
   end
   assign ptr_in_concurrent_out = word_addr <
      (size_8k_in ? `BPSC_STALL_8K : `BPSC_STALL_4K);
   assign page_number_field_out = size_8k_in ? pointer_in[13:7]
                                             : pointer_in[12:6];
   assign in_page_word_index_out = size_8k_in ? pointer_in[6:1]
                                              : {1'b0, pointer_in[5:1]};
   assign byte_sel_out = pointer_in[0];
endmodule // bpsc_addr_map

// >>> bench/bpsc_monitor.sv
// Port-level assertions for the self-programming controller.
`timescale 1ns/1ps
module bpsc_monitor #(
   parameter int PROG_CYCLES = 20
) (
   input logic        ref_clk_in,
   input logic        reset_n_in,
   input logic        size_8k_in,
   input logic [1:0]  boot_size_fuse_in,
   input logic        global_int_en_in,
   input logic        spm_exec_in,
   input logic [15:0] pointer_in,
   input logic        lpm_exec_in,
   input logic        flash_erase_out,
   input logic        flash_write_out,
   input logic [6:0]  flash_page_out,
   input logic        buf_fill_out,
   input logic [5:0]  buf_word_out,
   input logic        lpm_byte_sel_out,
   input logic        concurrent_read_blocked_out,
   input logic        lpm_addr_blocked_out,
   input logic        cpu_halt_out,
   input logic [12:0] boot_start_out,
   input logic        prog_ready_irq_out
);
   // Halt must end no more than four cycles after the shortened programming time.
   localparam int DONE_MAX = PROG_CYCLES + 4;
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!reset_n_in);
   sequence s_prog_start; flash_erase_out || flash_write_out; endsequence
   sequence s_quiet; !prog_ready_irq_out [*8]; endsequence
   function automatic logic [12:0] boot_of(logic s, logic [1:0] f);
      return {s, f == 2'h3 ? 12'hF80 : f == 2'h2 ? 12'hF00 :
              f == 2'h1 ? 12'hE00 : 12'hC00};
   endfunction
   a_ready_needs_gie: assert property (
      prog_ready_irq_out |-> global_int_en_in) else $error("irq no gie");
   a_quiet_while_prog: assert property (
      s_prog_start |=> s_quiet) else $error("ready during program");
   a_halt_bounded: assert property (
      s_prog_start |-> ##[1:DONE_MAX] !cpu_halt_out) else $error("halt");
   a_prog_cause: assert property (
      s_prog_start |-> $past(spm_exec_in)) else $error("pulse no spm");
   a_page_field: assert property (
      s_prog_start |-> flash_page_out == (size_8k_in ?
      $past(pointer_in[13:7]) : $past(pointer_in[12:6])))
      else $error("page select wrong");
   a_word_index: assert property (
      buf_fill_out |-> buf_word_out == (size_8k_in ? $past(pointer_in[6:1])
      : {1'b0, $past(pointer_in[5:1])})) else $error("word index wrong");
   a_byte_select: assert property (
      lpm_byte_sel_out == pointer_in[0]) else $error("byte select wrong");
   a_busy_rise: assert property (
      $rose(concurrent_read_blocked_out) |-> s_prog_start)
      else $error("busy set without program");
   a_read_block: assert property (
      lpm_addr_blocked_out == (concurrent_read_blocked_out && lpm_exec_in &&
      (size_8k_in ? pointer_in[13:1] < 13'h1C00
                  : pointer_in[12:1] < 12'hC00)))
      else $error("read blocked wrongly");
   a_boot_start: assert property (
      $past(reset_n_in) |-> boot_start_out ==
      boot_of(size_8k_in, boot_size_fuse_in)) else $error("boot start");
endmodule // bpsc_monitor

// >>> bench/bpsc_core_model.sv
// Behavioural processor core issuing store and load to program memory.
`timescale 1ns/1ps
module bpsc_core_model (
   input  logic        ref_clk_in,
   output logic        spm_exec_out = 1'b0,
   output logic [15:0] pointer_out = 16'h0000,
   output logic [15:0] spm_data_out = 16'h0000,
   output logic        lpm_exec_out = 1'b0,
   output logic        global_int_en_out = 1'b1
);
   // A gap of one cycle models a slow core still inside the arm window.
   task automatic spm(input logic [15:0] ptr, dat, input int gap);
      repeat (gap) @(posedge ref_clk_in);
      @(posedge ref_clk_in);
      spm_exec_out <= 1'b1;
      pointer_out  <= {ptr[15:1], 1'b0};
      spm_data_out <= dat;
      @(posedge ref_clk_in);
      spm_exec_out <= 1'b0;
   endtask
   task automatic drive(input logic lpm, gie);
      @(posedge ref_clk_in);
      lpm_exec_out      <= lpm;
      global_int_en_out <= gie;
   endtask
endmodule // bpsc_core_model

// >>> bench/bpsc_ctrl_test.sv
// Self-checking bench for the self-programming controller.
`timescale 1ns/1ps
module bpsc_ctrl_test;
   logic ref_clk_in = 0, reset_n_in = 0, clk_en_in = 1, size_8k_in = 0;
   logic [1:0] boot_size_fuse_in = 0;
   logic [7:0] reg_addr_in = 0, reg_wdata_in = 0, reg_rdata_out;
   logic reg_wr_in = 0, reg_rd_in = 0, rd_p = 0, c;
   logic spm_exec_in, lpm_exec_in, global_int_en_in, buf_clear_out;
   logic flash_erase_out, flash_write_out, buf_fill_out, irq_out;
   logic [15:0] pointer_in, spm_data_in, buf_data_out, p, pw, d;
   logic [6:0] flash_page_out, pg;
   logic [5:0] buf_word_out;
   logic lpm_byte_sel_out, concurrent_read_blocked_out, lpm_addr_blocked_out;
   logic cpu_halt_out, prog_ready_irq_out;
   logic [12:0] boot_start_out;
   logic [11:0] boot_lo [4] = '{12'hC00, 12'hE00, 12'hF00, 12'hF80};
   logic [31:0] exp_q [$];
   int errors = 0, compares = 0;
   always #10 ref_clk_in = ~ref_clk_in;
   bpsc_ctrl #(.PROG_CYCLES(20)) i_dut (.*);
   bpsc_core_model i_core (.ref_clk_in(ref_clk_in), .spm_exec_out(spm_exec_in),
      .pointer_out(pointer_in), .spm_data_out(spm_data_in),
      .lpm_exec_out(lpm_exec_in), .global_int_en_out(global_int_en_in));
   task automatic finish_test;
      errors += exp_q.size();
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   function automatic logic [31:0] nxt();
      return exp_q.size() ? exp_q.pop_front() : 32'hFFFFFFFF;
   endfunction
   // ----------------------------------------------------------------
   // Result watcher
   // ----------------------------------------------------------------
   always @(posedge ref_clk_in) begin
      if (rd_p) cmp({24'h0, reg_rdata_out}, nxt());
      if (flash_erase_out | flash_write_out | buf_fill_out)
         cmp({flash_erase_out, flash_write_out, buf_fill_out,
            buf_fill_out ? 7'h00 : flash_page_out,
            buf_fill_out ? {buf_word_out, buf_data_out} : 22'h0}, nxt());
      rd_p <= reg_rd_in;
   end
   task automatic wr(input logic [7:0] a, v);
      @(posedge ref_clk_in);
      reg_addr_in  <= a;
      reg_wdata_in <= v;
      reg_wr_in    <= 1'b1;
      @(posedge ref_clk_in);
      reg_wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, e);
      exp_q.push_back({24'h0, e});
      @(posedge ref_clk_in);
      reg_addr_in <= a;
      reg_rd_in   <= 1'b1;
      @(posedge ref_clk_in);
      reg_rd_in <= 1'b0;
   endtask
   // A limit that runs out means the operation never finished.
   task automatic wait_ready;
      int n;
      n = 0;
      while (prog_ready_irq_out !== 1'b1 && n < 200) begin
         @(negedge ref_clk_in);
         n++;
      end
      if (prog_ready_irq_out !== 1'b1) begin
         errors++;
         finish_test;
      end
   endtask
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   task automatic run_ops(input logic s);
      for (int k = 0; k < 3; k++) begin
         p = (k == 0) ? 16'($urandom) : s ? 16'hC000 | (16'h3700 +
            16'(k) * 16'h0080) : 16'hE000 | (16'h1780 + 16'(k) * 16'h0040);
         p = p & (s ? 16'hFF80 : 16'hFFC0);
         c = (s ? p[13:1] : {1'b0, p[12:1]}) < (s ? 13'h1C00 : 13'h0C00);
         pg = s ? p[13:7] : p[12:6];
         wr(8'h37, 8'h83);
         exp_q.push_back({3'b100, pg, 22'h0});
         i_core.spm(p, 16'h0000, k % 2);
         @(negedge ref_clk_in) cmp(32'(cpu_halt_out), 32'(!c));
         rd(8'h37, {1'b1, c, 6'h03});
         i_core.drive(1'b1, 1'b1);
         @(negedge ref_clk_in) cmp(32'(lpm_addr_blocked_out), 32'(c));
         i_core.drive(1'b0, 1'b1);
         wait_ready;
         rd(8'h37, {1'b1, c, 6'h00});
         for (int m = 0; m < 2; m++) begin
            wr(8'h39, 8'(m));
            @(negedge ref_clk_in) cmp(32'(irq_out), 32'(m[0]));
         end
         wr(8'h38, 8'h03);
         rd(8'h38, 8'h00);
         @(negedge ref_clk_in) cmp(32'(irq_out), 32'h0);
         i_core.drive(1'b0, 1'b0);
         @(negedge ref_clk_in) cmp(32'(prog_ready_irq_out), 32'h0);
         i_core.drive(1'b0, 1'b1);
         @(negedge ref_clk_in) cmp(32'(prog_ready_irq_out), 32'h1);
         pw = p | (16'($urandom) & (s ? 16'h007E : 16'h003E));
         d = 16'($urandom);
         wr(8'h37, 8'h81);
         exp_q.push_back({3'b001, 7'h0,
            s ? pw[6:1] : {1'b0, pw[5:1]}, d});
         // Freeze longer than the arm window; the fill must still land.
         clk_en_in <= 1'b0;
         repeat (6) @(posedge ref_clk_in);
         clk_en_in <= 1'b1;
         i_core.spm(pw, d, 0);
         rd(8'h37, 8'h80);
         wr(8'h37, 8'h85);
         exp_q.push_back({3'b010, pg, 22'h0});
         i_core.spm(p, 16'h0000, 1);
         rd(8'h37, {1'b1, c, 6'h05});
         wait_ready;
         wr(8'h37, 8'h91);
         i_core.spm(p, 16'h0000, 0);
         @(negedge ref_clk_in) cmp(32'(buf_clear_out), 32'h1);
         rd(8'h37, 8'h80);
         // Lock set is consumed without effect.
         wr(8'h37, 8'h89);
         i_core.spm(p, 16'h0000, 0);
         rd(8'h37, 8'h80);
         // An armed command with no store expires after four cycles.
         wr(8'h37, 8'h83);
         repeat (5) @(posedge ref_clk_in);
         rd(8'h37, 8'h80);
         wr(8'h37, 8'h20);
         rd(8'h37, 8'h00);
         wr(8'h38, 8'h03);
         rd(8'h50, 8'h00);
      end
   endtask
   initial begin
      void'($urandom(32'h440A));
      for (int cfg = 0; cfg < 8; cfg++) begin
         @(posedge ref_clk_in);
         reset_n_in        <= 1'b0;
         size_8k_in        <= cfg[2];
         boot_size_fuse_in <= cfg[1:0];
         repeat (3) @(posedge ref_clk_in);
         reset_n_in <= 1'b1;
         repeat (2) @(posedge ref_clk_in);
         @(negedge ref_clk_in);
         cmp(32'(boot_start_out),
            32'({cfg[2], boot_lo[cfg[1:0]]}));
         rd(8'h37, 8'h00);
         run_ops(cfg[2]);
      end
      repeat (3) @(posedge ref_clk_in);
      finish_test;
   end
endmodule // bpsc_ctrl_test
bind bpsc_ctrl bpsc_monitor #(.PROG_CYCLES(PROG_CYCLES)) i_mon (.*);
